// [bench/per_encoder.sv]
`timescale 1ns/1ps

module per_encoder
(
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic rst_in,
	// Motion commands
	input  wire logic step_in,
	input  wire logic back_in,
	input  wire logic skip_in,
	input  wire logic idx_in,
	// Encoder pins
	output logic      phase_a_out,
	output logic      phase_b_out,
	output logic      index_out
);
	logic [1:0] pos_ff;

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			pos_ff <= 2'h0;
		else if (skip_in)
			pos_ff <= pos_ff + 2'h2;
		else if (step_in)
			pos_ff <= back_in ? pos_ff - 2'h1 : pos_ff + 2'h1;
	end

	always_ff @(posedge clock_in)
		index_out <= !rst_in && idx_in;

	// Forward order of {B,A}: 00, 10, 11, 01
	assign {phase_a_out, phase_b_out} = pos_ff ^ {1'h0, pos_ff[1]};
endmodule : per_encoder

// [bench/per_router_checker.sv]
`timescale 1ns/1ps

module per_router_checker
	import per_pkg::*;
(
	input  wire logic               clock_in,
	input  wire logic               rst_in,
	input  wire logic               hsel_in,
	input  wire logic [31:0]        haddr_in,
	input  wire logic [1:0]         htrans_in,
	input  wire logic               hwrite_in,
	input  wire logic [31:0]        hwdata_in,
	input  wire logic               hready_in,
	input  wire logic [31:0]        hrdata_out,
	input  wire logic               hreadyout_out,
	input  wire logic               hresp_out,
	input  wire logic [NUM_SRC-1:0] src_events_in,
	input  wire logic [NUM_CH-1:0]  event_trig_out,
	input  wire logic [NUM_CH-1:0]  event_data_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);

	logic        wr_ff;
	logic        tw_ff;
	logic        f1_ff;
	logic [31:0] ad_ff;
	logic [7:0]  s1_ff;
	wire         req = hsel_in && hready_in && htrans_in[1];
	wire         rt  = s1_ff inside {[8'h01:8'h0F]};

	// Shadow of channel 1 setup and trigger writes
	always_ff @(posedge clock_in)
	begin
		wr_ff <= !rst_in && req && hwrite_in;
		ad_ff <= haddr_in;
		tw_ff <= !rst_in && wr_ff && ad_ff == 32'h24;
		if (rst_in)
			s1_ff <= 8'h00;
		else if (wr_ff && ad_ff == 32'h04)
			s1_ff <= hwdata_in[7:0];
		if (rst_in)
			f1_ff <= 1'h0;
		else if (wr_ff && ad_ff == 32'h14)
			f1_ff <= hwdata_in[CTRL_FLT_EN];
	end

	AST_ROUTE: assert property (!tw_ff && !wr_ff && !f1_ff && rt |=>
		event_trig_out[1] == $past(src_events_in[s1_ff[3:0]])) else $error("routed event mismatch");
	AST_NONE: assert property (!tw_ff && !wr_ff && !f1_ff && !rt && s1_ff != SEL_PERIODIC |=>
		!event_trig_out[1]) else $error("event on unrouted channel");
	AST_SWT: assert property (wr_ff && ad_ff == 32'h24 && hwdata_in[1] |-> ##2 event_trig_out[1])
		else $error("software trigger lost");
	AST_DATA: assert property (!tw_ff |=> !event_data_out[1]) else $error("stray data bit");
	AST_RD: assert property (req && !hwrite_in && haddr_in == 32'h20 |=> hrdata_out[31:4] == 28'h0)
		else $error("software data upper bits set");
	AST_UNMAP: assert property (req && !hwrite_in && haddr_in[31:12] != 20'h0 |=> hrdata_out == 32'h0)
		else $error("unmapped read not zero");
	AST_RESP: assert property (hresp_out == HRESP_OKAY) else $error("response not okay");
	AST_RDY: assert property (!$past(rst_in) |-> hreadyout_out) else $error("bus stalled");

	cover property (tw_ff);
	cover property (rt && src_events_in[s1_ff[3:0]]);
	cover property (s1_ff == SEL_PERIODIC && event_trig_out[1]);
endmodule : per_router_checker

bind per_router per_router_checker u_per_router_checker (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel_in),
	.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
	.hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
	.src_events_in(src_events_in), .event_trig_out(event_trig_out), .event_data_out(event_data_out));

// [bench/peripheral_event_router_test.sv]
`timescale 1ns/1ps

module peripheral_event_router_test
	import per_pkg::*;
;
	logic        clock_in, rst_in, hsel, hwrite, hresp, hrdy, pa, pb, pi, rnd, p;
	logic [3:0]  qc, c, t, d, trig, data;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, k;
	logic [15:0] src, lvl, lf;
	int          miscompares, n_tests, i, n;

	per_router u_per_router (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
		.hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .src_events_in(src),
		.phase_a_input_in(pa), .phase_b_input_in(pb), .index_input_in(pi), .event_trig_out(trig),
		.event_data_out(data));
	per_encoder u_per_encoder (.clock_in(clock_in), .rst_in(rst_in), .step_in(qc[3]), .back_in(qc[2]),
		.skip_in(qc[1]), .idx_in(qc[0]), .phase_a_out(pa), .phase_b_out(pb), .index_out(pi));

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wt;
		int j;
		j = 0;
		@(posedge clock_in);
		while (hrdy !== 1'h1)
		begin
			j++;
			if (j > 50)
			begin
				miscompares++;
				give_verdict;
			end
			@(posedge clock_in);
		end
	endtask : wt

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dw, output logic [31:0] rd);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wt;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= dw;
		wt;
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] dw);
		logic [31:0] x;
		bus(1'h1, a, dw, x);
	endtask : wr

	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'h0, a, 32'h0, x);
		chk(nm, e, x);
	endtask : rdc

	// Sum of trig*2+data on channel 0 after one encoder command
	task automatic quad(input logic [3:0] cmd, input logic [31:0] e);
		logic [31:0] s;
		s = 0;
		qc <= cmd;
		@(posedge clock_in);
		qc <= 4'h0;
		repeat (10)
		begin
			@(posedge clock_in);
			s += 2 * trig[0] + data[0];
		end
		chk("quad", e, s);
	endtask : quad

	always @(posedge clock_in)
	begin
		if (rst_in)
			lf <= 16'h0034;
		else
			lf <= lfsr_next(lf);
		src <= rnd ? lf : lvl;
	end

	initial
	begin
		clock_in = 1'h0;
		forever #50 clock_in = ~clock_in;
	end

	initial
	begin
		{hsel, hwrite, htrans, haddr, hwdata, qc, rnd, lvl} = '0;
		rst_in = 1'h1;
		repeat (5) @(posedge clock_in);
		rst_in <= 1'h0;
		for (i = 0; i < 11; i++)
			rdc("reset", i * 4, 32'h0);
		rdc("unmapped", 32'h1000, 32'h0);
		rnd <= 1'h1;
		for (i = 0; i < 6; i++)
		begin
			c = (lf[3:0] == 4'h0) ? 4'hF : lf[3:0];
			wr(32'h04, {28'h0, c});
			wr(32'h08, {28'h0, c});
			rdc("select", 32'h04, {28'h0, c});
			p = src[c];
			repeat (20)
			begin
				@(posedge clock_in);
				chk("route", {30'h0, p, p}, {30'h0, trig[2:1]});
				p = src[c];
			end
		end
		wr(32'h04, 32'h35);
		@(posedge clock_in);
		repeat (20)
		begin
			@(posedge clock_in);
			chk("absent", 32'h0, {31'h0, trig[1]});
		end
		rnd <= 1'h0;
		wr(32'h04, 32'h0);
		wr(32'h08, 32'h0);
		for (i = 0; i < 10; i++)
		begin
			t = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : lf[3:0];
			d = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : lf[7:4];
			wr(32'h20, {28'h0, d});
			wr(32'h24, {28'h0, t});
			repeat (2) @(posedge clock_in);
			chk("software", {t, d}, {trig, data});
			@(posedge clock_in);
			chk("software end", 8'h00, {trig, data});
			rdc("software regs", 32'h24, {28'h0, t});
		end
		wr(32'h04, {24'h0, SEL_PERIODIC});
		for (i = 0; i < 4; i++)
		begin
			n = (i == 3) ? 15 : 2 * i + (i == 2);
			k = 0;
			wr(32'h14, n);
			repeat (40) @(posedge clock_in);
			repeat ((i == 3) ? 32768 : 64)
			begin
				@(posedge clock_in);
				k += trig[1];
			end
			chk("periodic", ((i == 3) ? 32768 : 64) >> n, k);
		end
		wr(32'h04, 32'h05);
		wr(32'h14, 32'h0A0);
		for (i = 0; i < 2; i++)
		begin
			k = 0;
			lvl <= 16'h0020;
			@(posedge clock_in);
			lvl <= (i == 0) ? 16'h0 : 16'h0020;
			repeat (10)
			begin
				@(posedge clock_in);
				k += trig[1];
			end
			chk("filter", i, k != 0);
		end
		lvl <= 16'h0;
		wr(32'h04, 32'h0);
		wr(32'h14, 32'h200);
		wr(32'h10, 32'h200);
		quad(4'h8, 3);
		quad(4'hC, 2);
		quad(4'h2, 0);
		quad(4'h1, 1);
		give_verdict;
	end
endmodule : peripheral_event_router_test

// [src/per_pkg.sv]
package per_pkg;

	// Channel and source counts, field widths
	localparam int          NUM_CH        = 4;
	localparam int          NUM_SRC       = 16;
	localparam int          SEL_W         = 8;
	localparam int          CTRL_W        = 10;
	localparam int          PSC_W         = 15;
	localparam int          FLT_CNT_W     = 3;

	// Register byte addresses
	localparam logic [11:0] ADDR_SEL_BASE  = 12'h000;
	localparam logic [11:0] ADDR_CTRL_BASE = 12'h010;
	localparam logic [11:0] ADDR_SW_DATA   = 12'h020;
	localparam logic [11:0] ADDR_SW_TRIG   = 12'h024;
	localparam logic [11:0] ADDR_STATUS    = 12'h028;

	// Control register fields
	localparam int          CTRL_PSC_LSB  = 0;
	localparam int          CTRL_PSC_W    = 4;
	localparam int          CTRL_FLT_EN   = 5;
	localparam int          CTRL_FLT_LSB  = 6;
	localparam int          CTRL_QD_EN    = 9;

	// Status register fields
	localparam int          STAT_TRIG_LSB = 0;
	localparam int          STAT_DATA_LSB = 4;
	localparam int          STAT_PHASE_LSB = 8;

	// Source select codes
	localparam logic [7:0]  SEL_NONE      = 8'h00;
	localparam logic [7:0]  SEL_PERIODIC  = 8'hF0;

	// Reset values
	localparam logic [7:0]  SEL_RESET     = 8'h00;
	localparam logic [9:0]  CTRL_RESET    = 10'h000;

	// Bus encodings
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'h0;

endpackage : per_pkg

// [src/per_router.sv]
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - Four independent source-to-user event channels
// - Generator to user within two clocks
// - Routing runs regardless of sleep state
// - One source may feed several channels
// - Per-channel prescaler divides by 1..32768
// - Trigger write fires events on set channels
// - One data/trigger bit per channel
// - Software event lasts one cycle, overrides
// - Trigger/data pairs encode data events 01-03
// - Signaling users see only trigger bit
// - Events one cycle, level sources continuous
// - Optional filter needs N equal samples
// - Single quadrature decoder on channel zero
// - Decoder pairs: index, down, up, none
// - Select zero routes only software and channel-zero decoder events
// - Absent source codes act like zero
// - Phase B leading counts up
module per_router
	import per_pkg::*;
(
	// Clock and reset
	input  wire logic                clock_in,
	input  wire logic                rst_in,
	// AHB-Lite slave
	input  wire logic                hsel_in,
	input  wire logic [31:0]         haddr_in,
	input  wire logic [1:0]          htrans_in,
	input  wire logic                hwrite_in,
	input  wire logic [2:0]          hsize_in,
	input  wire logic [31:0]         hwdata_in,
	input  wire logic                hready_in,
	output logic      [31:0]         hrdata_out,
	output logic                     hreadyout_out,
	output logic                     hresp_out,
	// Event generators
	input  wire logic [NUM_SRC-1:0]  src_events_in,
	// Quadrature pins
	input  wire logic                phase_a_input_in,
	input  wire logic                phase_b_input_in,
	input  wire logic                index_input_in,
	// Event channels to users
	output logic      [NUM_CH-1:0]   event_trig_out,
	output logic      [NUM_CH-1:0]   event_data_out
);

	logic [SEL_W-1:0]     sel_ff [NUM_CH];
	logic [CTRL_W-1:0]    ctrl_ff [NUM_CH];
	logic [NUM_CH-1:0]    sw_data_ff;
	logic [NUM_CH-1:0]    sw_trig_ff;
	logic [NUM_CH-1:0]    sw_fire_ff;
	logic                 wr_pend_ff;
	logic [11:0]          wr_addr_ff;
	logic [31:0]          hrdata_ff;
	logic [NUM_CH-1:0]    trig_ff;
	logic [NUM_CH-1:0]    data_ff;
	logic [2:0]           pin_s1_ff;
	logic [2:0]           pin_s2_ff;
	logic [1:0]           phase_ff;
	logic                 index_prev_ff;
	logic                 qd_trig_ff;
	logic                 qd_data_ff;
	logic                 addr_phase;
	logic [NUM_CH-1:0]    nxt_trig;
	logic [NUM_CH-1:0]    nxt_data;
	logic [NUM_CH-1:0]    route_level;
	logic [1:0]           phase_now;
	logic [31:0]          nxt_rdata;

	// Bus address phase accepted
	assign addr_phase = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ || htrans_in == 2'h3);

	// Capture write address for the data phase
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 12'h000;
		end
		else if (hready_in)
		begin
			wr_pend_ff <= addr_phase && hwrite_in;
			wr_addr_ff <= haddr_in[11:0];
		end
	end

	// Zero wait state, always OKAY
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			hreadyout_out <= 1'b0;
			hresp_out     <= HRESP_OKAY;
		end
		else
		begin
			hreadyout_out <= 1'b1;
			hresp_out     <= HRESP_OKAY;
		end
	end

	// Configuration registers
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				sel_ff[i]  <= SEL_RESET;
				ctrl_ff[i] <= CTRL_RESET;
			end
			sw_data_ff <= 4'h0;
		end
		else if (wr_pend_ff)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (wr_addr_ff == ADDR_SEL_BASE + 12'(4 * i))
					sel_ff[i] <= hwdata_in[SEL_W-1:0];
				if (wr_addr_ff == ADDR_CTRL_BASE + 12'(4 * i))
					ctrl_ff[i] <= hwdata_in[CTRL_W-1:0];
			end
			if (wr_addr_ff == ADDR_SW_DATA)
				sw_data_ff <= hwdata_in[NUM_CH-1:0];
		end
	end

	// Software trigger: one-cycle fire per channel
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			sw_trig_ff <= 4'h0;
			sw_fire_ff <= 4'h0;
		end
		else if (wr_pend_ff && wr_addr_ff == ADDR_SW_TRIG)
		begin
			sw_trig_ff <= hwdata_in[NUM_CH-1:0];
			sw_fire_ff <= hwdata_in[NUM_CH-1:0] | sw_data_ff;
		end
		else
		begin
			sw_fire_ff <= 4'h0;
		end
	end

	// Read data prepared in the address phase
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (haddr_in[11:0] == ADDR_SEL_BASE + 12'(4 * i))
				nxt_rdata[SEL_W-1:0] = sel_ff[i];
			if (haddr_in[11:0] == ADDR_CTRL_BASE + 12'(4 * i))
				nxt_rdata[CTRL_W-1:0] = ctrl_ff[i];
		end
		if (haddr_in[11:0] == ADDR_SW_DATA)
			nxt_rdata[NUM_CH-1:0] = sw_data_ff;
		if (haddr_in[11:0] == ADDR_SW_TRIG)
			nxt_rdata[NUM_CH-1:0] = sw_trig_ff;
		if (haddr_in[11:0] == ADDR_STATUS)
		begin
			nxt_rdata[STAT_TRIG_LSB +: NUM_CH] = trig_ff;
			nxt_rdata[STAT_DATA_LSB +: NUM_CH] = data_ff;
			nxt_rdata[STAT_PHASE_LSB +: 2]     = phase_ff;
		end
		if (haddr_in[31:12] != 20'h00000)
			nxt_rdata = 32'h0000_0000;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			hrdata_ff <= 32'h0000_0000;
		else if (addr_phase && !hwrite_in)
			hrdata_ff <= nxt_rdata;
	end

	assign hrdata_out = hrdata_ff;

	// Pin synchronisers: phase A, phase B, index
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			pin_s1_ff <= 3'h0;
			pin_s2_ff <= 3'h0;
		end
		else
		begin
			pin_s1_ff <= {index_input_in, phase_b_input_in, phase_a_input_in};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign phase_now = pin_s2_ff[1:0];

	// Quadrature decoder, channel zero only
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			phase_ff      <= 2'h0;
			index_prev_ff <= 1'b0;
			qd_trig_ff    <= 1'b0;
			qd_data_ff    <= 1'b0;
		end
		else
		begin
			phase_ff      <= phase_now;
			index_prev_ff <= pin_s2_ff[2];
			qd_trig_ff    <= 1'b0;
			qd_data_ff    <= 1'b0;
			if (pin_s2_ff[2] && !index_prev_ff)
			begin
				qd_data_ff <= 1'b1;
			end
			else
			begin
				// State {B,A}: forward 00->10->11->01->00
				unique case ({phase_ff, phase_now})
					4'h2, 4'hB, 4'hD, 4'h4:
					begin
						qd_trig_ff <= 1'b1;
						qd_data_ff <= 1'b1;
					end
					4'h1, 4'h7, 4'hE, 4'h8:
					begin
						qd_trig_ff <= 1'b1;
						qd_data_ff <= 1'b0;
					end
					default:
					begin
						qd_trig_ff <= 1'b0;
						qd_data_ff <= 1'b0;
					end
				endcase
			end
		end
	end

	// Per-channel multiplexer, prescaler and filter
	generate
		for (genvar ch = 0; ch < NUM_CH; ch++)
		begin : g_ch
			logic [PSC_W-1:0]     psc_cnt_ff;
			logic                 tick_ff;
			logic                 flt_prev_ff;
			logic                 flt_out_ff;
			logic [FLT_CNT_W-1:0] flt_cnt_ff;
			logic [PSC_W-1:0]     psc_mask;
			logic                 raw;
			logic [FLT_CNT_W-1:0] flt_len;

			assign psc_mask = PSC_W'((16'h0001 << ctrl_ff[ch][CTRL_PSC_LSB +: CTRL_PSC_W]) - 16'h0001);
			assign flt_len  = ctrl_ff[ch][CTRL_FLT_LSB +: FLT_CNT_W];

			// Periodic tick every 2^n clocks
			always_ff @(posedge clock_in)
			begin
				if (rst_in)
				begin
					psc_cnt_ff <= 15'h0000;
					tick_ff    <= 1'b0;
				end
				else if (psc_cnt_ff >= psc_mask)
				begin
					psc_cnt_ff <= 15'h0000;
					tick_ff    <= 1'b1;
				end
				else
				begin
					psc_cnt_ff <= psc_cnt_ff + 15'h0001;
					tick_ff    <= 1'b0;
				end
			end

			// Source select; zero and absent codes route nothing
			always_comb
			begin
				raw = 1'b0;
				if (sel_ff[ch] == SEL_PERIODIC)
					raw = tick_ff;
				else if (sel_ff[ch] != SEL_NONE && sel_ff[ch] < 8'(NUM_SRC))
					raw = src_events_in[sel_ff[ch][3:0]];
			end

			// Filter: accept after flt_len+2 equal samples
			always_ff @(posedge clock_in)
			begin
				if (rst_in)
				begin
					flt_prev_ff <= 1'b0;
					flt_cnt_ff  <= 3'h0;
					flt_out_ff  <= 1'b0;
				end
				else
				begin
					flt_prev_ff <= raw;
					if (raw != flt_prev_ff)
						flt_cnt_ff <= 3'h0;
					else if (flt_cnt_ff != flt_len)
						flt_cnt_ff <= flt_cnt_ff + 3'h1;
					if (raw == flt_prev_ff && flt_cnt_ff == flt_len)
						flt_out_ff <= raw;
				end
			end

			// Channel result before the output register
			always_comb
			begin
				route_level[ch] = ctrl_ff[ch][CTRL_FLT_EN] ? flt_out_ff : raw;
				nxt_trig[ch]    = route_level[ch];
				nxt_data[ch]    = 1'b0;
				if (ch == 0 && ctrl_ff[ch][CTRL_QD_EN])
				begin
					nxt_trig[ch] = qd_trig_ff;
					nxt_data[ch] = qd_data_ff;
				end
				if (sw_fire_ff[ch])
				begin
					nxt_trig[ch] = sw_trig_ff[ch];
					nxt_data[ch] = sw_data_ff[ch];
				end
			end
		end
	endgenerate

	// Registered channel outputs, no sleep gating
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			trig_ff <= 4'h0;
			data_ff <= 4'h0;
		end
		else
		begin
			trig_ff <= nxt_trig;
			data_ff <= nxt_data;
		end
	end

	// Signaling users take only the trigger line
	assign event_trig_out = trig_ff;
	assign event_data_out = data_ff;

endmodule : per_router
